// ===== hdl/acs_host.sv
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
`include "acs_map.svh"
module acs_host #(
    parameter int DIV  = 8,
    parameter int STRB = 12
) (
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    acs_if.host              LINK,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    output logic      [31:0] HRDATA_O
);
    import acs_pkg::*;

    if (DIV < 6 || DIV % 2 != 0 || DIV > 256) begin : g_bad_div
        $error("DIV must be even and between 6 and 256");
    end
    if (STRB < 11 || STRB > 256) begin : g_bad_strb
        $error("STRB must be between 11 and 256");
    end

    localparam int ACQ_CYC =
        (`ACS_ACQ_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS;
    localparam logic [7:0] ACQ_C  = 8'(ACQ_CYC - 1);
    localparam logic [7:0] STRB_C = 8'(STRB - 1);
    localparam logic [7:0] HALF_C = 8'(DIV / 2 - 1);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [`ACS_HS_W-1:0] sy1;
        logic [`ACS_HS_W-1:0] sy2;
        logic [`ACS_HS_W-1:0] sy3;
        logic [`ACS_HS_W-1:0] filt;
        acs_hstate_t          state;
        logic [7:0]           cnt;
        logic [7:0]           div;
        logic                 mclk;
        logic                 hi;
        logic                 conversion_start_n_n;
        logic                 cs_n;
        logic                 wr_n;
        logic                 rd_n;
        logic [11:0]          db;
        logic [11:0]          db_oe_n;
        logic [11:0]          ctrlw;
        logic                 word;
        logic [11:0]          res;
        logic [1:0]           res_ch;
        logic                 valid;
        logic                 ap_wr;
        logic [7:0]           ap_addr;
        logic [31:0]          rdata;
    } acs_host_st_t;

    localparam acs_host_st_t HOST_RST = '{
        state: H_INIT, cs_n: 1'h1, wr_n: 1'h1, rd_n: 1'h1,
        db_oe_n: `ACS_OE_OFF, word: 1'h1, default: '0
    };

    acs_host_st_t         r;
    acs_host_st_t         n;
    logic [`ACS_HS_W-1:0] diff;
    logic [11:0]          db_f;
    logic                 acc;
    logic                 tick_s;

    assign diff   = r.sy2 ^ r.sy3;
    assign db_f   = r.filt[`ACS_HS_DB_HI:`ACS_HS_DB_LO];
    assign acc    = HSEL_I & HTRANS_I[`ACS_HTRANS_NSQ] & HREADY_I;
    assign tick_s = (r.cnt == STRB_C);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        n = r;
        n.sy1 = {LINK.db, LINK.busy};
        n.sy2 = r.sy1;
        n.sy3 = r.sy2;
        n.filt = (r.sy2 & ~diff) | (r.filt & diff);
        n.cnt = r.cnt + 8'h01;

        // Master clock divider
        n.div = r.div + 8'h01;
        if (r.div == HALF_C) begin
            n.div = 8'h00;
            n.mclk = ~r.mclk;
        end

        // Bus slave
        n.ap_wr = acc & HWRITE_I;
        n.ap_addr = HADDR_I[7:0];
        if (acc && !HWRITE_I) begin
            if (HADDR_I[7:0] == `ACS_A_CTRLW) begin
                n.rdata = {20'h00000, r.ctrlw};
            end else if (HADDR_I[7:0] == `ACS_A_CMD) begin
                n.rdata = {30'h0, r.filt[`ACS_HS_BUSY],
                           r.state != H_IDLE};
            end else if (HADDR_I[7:0] == `ACS_A_CFG) begin
                n.rdata = {31'h0, r.word};
            end else if (HADDR_I[7:0] == `ACS_A_RES) begin
                n.rdata = {r.valid, 17'h0, r.res_ch, r.res};
                n.valid = 1'h0;
            end else begin
                n.rdata = 32'h0;
            end
        end
        if (r.ap_wr && r.ap_addr == `ACS_A_CTRLW) begin
            n.ctrlw = HWDATA_I[11:0];
        end else if (r.ap_wr && r.ap_addr == `ACS_A_CFG) begin
            n.word = HWDATA_I[0];
        end

        // Link sequencing
        case (r.state)
            H_INIT: begin
                if (r.cnt == ACQ_C) begin
                    n.conversion_start_n_n = 1'h1;                        // [RQ11]
                    n.state = H_IDLE;
                end
            end
            H_IDLE: begin
                n.cnt = 8'h00;
                n.hi = 1'h0;
                if (r.ap_wr && r.ap_addr == `ACS_A_CMD) begin
                    if (HWDATA_I[`ACS_CMD_WR]) begin
                        n.state = H_WSET;                     // [RQ2]
                    end else if (HWDATA_I[`ACS_CMD_CONV]) begin
                        n.state = H_ACQ;
                    end
                end
            end
            H_WSET: begin
                n.cs_n = 1'h0;
                n.wr_n = 1'h0;
                n.db_oe_n = `ACS_OE_ON;
                if (r.word) begin
                    n.db = r.ctrlw;
                end else if (r.hi) begin
                    n.db = {3'h0, 1'h1, 4'h0, r.ctrlw[11:8]};
                end else begin
                    n.db = {4'h0, r.ctrlw[7:0]};
                end
                if (tick_s) begin
                    n.cnt = 8'h00;
                    n.state = H_WHOLD;
                end
            end
            H_WHOLD: begin
                n.wr_n = 1'h1;
                if (tick_s) begin
                    n.cnt = 8'h00;
                    n.cs_n = 1'h1;
                    n.db_oe_n = `ACS_OE_OFF;
                    if (!r.word && !r.hi) begin
                        n.hi = 1'h1;
                        n.state = H_WSET;
                    end else begin
                        n.state = H_IDLE;
                    end
                end
            end
            H_ACQ: begin
                if (r.cnt == ACQ_C) begin
                    n.state = H_CLOW;                         // [RQ12]
                end
            end
            H_CLOW: begin
                n.conversion_start_n_n = 1'h0;
                if (r.filt[`ACS_HS_BUSY]) begin
                    n.state = H_CBUSY;
                end
            end
            H_CBUSY: begin
                if (!r.filt[`ACS_HS_BUSY]) begin
                    n.conversion_start_n_n = 1'h1;                        // [RQ9]
                    n.cnt = 8'h00;
                    n.state = H_RSTB;
                end
            end
            H_RSTB: begin
                n.cs_n = 1'h0;                                // [RQ15]
                n.rd_n = 1'h0;
                n.db = {3'h0, r.hi, 8'h00};
                n.db_oe_n = r.word ? `ACS_OE_OFF : `ACS_OE_HBS;
                if (tick_s) begin
                    n.cnt = 8'h00;
                    n.state = H_RGAP;
                    if (r.word) begin
                        n.res = db_f;
                        n.res_ch = 2'h0;
                    end else if (r.hi) begin
                        n.res[11:8] = db_f[3:0];
                        n.res_ch = db_f[5:4];
                    end else begin
                        n.res[7:0] = db_f[7:0];
                    end
                end
            end
            H_RGAP: begin
                n.cs_n = 1'h1;
                n.rd_n = 1'h1;
                n.db_oe_n = `ACS_OE_OFF;
                if (tick_s) begin
                    n.cnt = 8'h00;
                    if (!r.word && !r.hi) begin
                        n.hi = 1'h1;
                        n.state = H_RSTB;
                    end else begin
                        n.valid = 1'h1;
                        n.state = H_IDLE;
                    end
                end
            end
            default: begin
                n.state = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            r <= HOST_RST;
        end else begin
            r <= n;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign LINK.conversion_start_n_n     = r.conversion_start_n_n;
    assign LINK.cs_n         = r.cs_n;
    assign LINK.wr_n         = r.wr_n;                        // [RQ5]
    assign LINK.rd_n         = r.rd_n;
    assign LINK.mclk         = r.mclk;
    assign LINK.word_mode    = r.word;
    assign LINK.host_db      = r.db;
    assign LINK.host_db_oe_n = r.db_oe_n;
    assign HREADYOUT_O       = 1'h1;
    assign HRESP_O           = 1'h0;
    assign HRDATA_O          = r.rdata;
endmodule

// ===== hdl/acs_map.svh
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
// Notes on behaviour
// [RQ1] Manual mode converts the addressed channel
// [RQ2] Host rewrites control before each channel change
// [RQ3] Sequence mode starts at channel 0, counts up
// [RQ4] Sequence wraps to 0 until next write
// [RQ5] Host keeps write strobe high during sequence
// [RQ6] Reference bit one selects internal reference
// [RQ7] Falling start edge begins a conversion
// [RQ8] Busy high for the whole conversion
// [RQ9] Early start rise aborts, track resumes
// [RQ10] Hold on start fall, track at rise 13
// [RQ11] Hold after power-up until start rises
// [RQ12] Host allows 125 ns acquisition first
// [RQ13] Start rise powers up in auto modes
// [RQ14] Twelve-bit port, word or byte mode
// [RQ15] Host reads with select and read strobe
// [RQ16] High byte: MSBs, channel id, zeros
// [RQ17] Control captured on write strobe rise
// [RQ18] Power bits reset to normal mode
// [RQ19] Address bits form channel index 0-3
// [RQ20] Other order codes mean manual mode

// ****************************************************************
// Control word layout
// ****************************************************************
`define ACS_CR_W        12
`define ACS_CR_RST      12'h000
`define ACS_CR_PM_HI    11
`define ACS_CR_PM_LO    10
`define ACS_CR_CHAN_ORDER_BIT1     9
`define ACS_CR_CHAN_ORDER_BIT0     8
`define ACS_CR_CHANNEL_INDEX_BIT1     7
`define ACS_CR_CHANNEL_INDEX_BIT0     6
`define ACS_CR_INPUT_CONFIG_BIT1    5
`define ACS_CR_INPUT_CONFIG_BIT0    4
`define ACS_CR_REF      3
`define ACS_PM_AUTOSHDN 2'h1
`define ACS_PM_AUTOSTBY 2'h2

// ****************************************************************
// Conversion timing in master clock edges and nanoseconds
// ****************************************************************
`define ACS_TRACK_RISE  4'hD
`define ACS_DONE_FALL   4'hE
`define ACS_ACQ_NS      125
`define ACS_CLK_NS      10

// ****************************************************************
// Device pin synchroniser layout
// ****************************************************************
`define ACS_SY_W        18
`define ACS_SY_RST      18'h0002E
`define ACS_SY_CONVERSION_START_N   0
`define ACS_SY_CS       1
`define ACS_SY_WR       2
`define ACS_SY_RD       3
`define ACS_SY_MCLK     4
`define ACS_SY_WB       5
`define ACS_SY_DB_LO    6
`define ACS_SY_DB_HI    17
`define ACS_HBS_BIT     8

// ****************************************************************
// Data bus enables, low while driving
// ****************************************************************
`define ACS_OE_ON       12'h000
`define ACS_OE_OFF      12'hFFF
`define ACS_OE_BYTE     12'hF00
`define ACS_OE_HBS      12'hEFF

// ****************************************************************
// Host pin synchroniser and register map
// ****************************************************************
`define ACS_HS_W        13
`define ACS_HS_RST      13'h0000
`define ACS_HS_BUSY     0
`define ACS_HS_DB_LO    1
`define ACS_HS_DB_HI    12
`define ACS_A_CTRLW     8'h00
`define ACS_A_CMD       8'h04
`define ACS_A_CFG       8'h08
`define ACS_A_RES       8'h0C
`define ACS_CMD_WR      0
`define ACS_CMD_CONV    1
`define ACS_RES_VALID   31
`define ACS_HTRANS_NSQ  1
`endif

// ===== hdl/acs_pkg.sv
package acs_pkg;
    typedef enum logic [0:0] {
        D_IDLE = 1'b0,
        D_CONV = 1'b1
    } acs_dstate_t;

    typedef enum logic [3:0] {
        H_INIT  = 4'b0000,
        H_IDLE  = 4'b0001,
        H_WSET  = 4'b0010,
        H_WHOLD = 4'b0011,
        H_ACQ   = 4'b0100,
        H_CLOW  = 4'b0101,
        H_CBUSY = 4'b0110,
        H_RSTB  = 4'b0111,
        H_RGAP  = 4'b1000
    } acs_hstate_t;
endpackage

// ===== hdl/acs_if.sv
`timescale 1ns/100ps
interface acs_if;
    logic        conversion_start_n_n;
    logic        cs_n;
    logic        wr_n;
    logic        rd_n;
    logic        mclk;
    logic        word_mode;
    logic        busy;
    logic [11:0] host_db;
    logic [11:0] host_db_oe_n;
    logic [11:0] dev_db;
    logic [11:0] dev_db_oe_n;
    logic [11:0] db;

    // Resolved data bus, pulled low where nobody drives
    assign db = (~dev_db_oe_n & dev_db) | (~host_db_oe_n & host_db);

    modport dev (
        input  conversion_start_n_n, cs_n, wr_n, rd_n, mclk, word_mode, db,
        output busy, dev_db, dev_db_oe_n
    );
    modport host (
        input  busy, db,
        output conversion_start_n_n, cs_n, wr_n, rd_n, mclk, word_mode,
        output host_db, host_db_oe_n
    );
endinterface

// ===== hdl/acs_dev.sv
`timescale 1ns/100ps
`include "acs_map.svh"
module acs_dev (
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    acs_if.dev               LINK,
    input  wire logic [11:0] SAMPLE_I,
    output logic      [1:0]  CHANNEL_O,
    output logic             HOLD_O,
    output logic             REF_INTERNAL_O,
    output logic      [1:0]  INPUT_CONFIG_O,
    output logic      [1:0]  POWER_MODE_O,
    output logic             POWER_DOWN_O
);
    import acs_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [`ACS_SY_W-1:0] sy1;
        logic [`ACS_SY_W-1:0] sy2;
        logic [`ACS_SY_W-1:0] sy3;
        logic [`ACS_SY_W-1:0] filt;
        acs_dstate_t          state;
        logic [3:0]           rise_cnt;
        logic [3:0]           fall_cnt;
        logic                 hold;
        logic                 busy;
        logic                 pdown;
        logic [`ACS_CR_W-1:0] ctrl;
        logic [7:0]           stage;
        logic [1:0]           seq_ch;
        logic [1:0]           mux_ch;
        logic [1:0]           cur_ch;
        logic [11:0]          sample;
        logic [11:0]          result;
        logic [1:0]           res_ch;
        logic [11:0]          dout;
        logic [11:0]          oe_n;
    } acs_dev_st_t;

    localparam acs_dev_st_t DEV_RST = '{
        sy1:   `ACS_SY_RST,
        sy2:   `ACS_SY_RST,
        sy3:   `ACS_SY_RST,
        filt:  `ACS_SY_RST,
        state: D_IDLE,
        hold:  1'h1,
        ctrl:  `ACS_CR_RST,
        oe_n:  `ACS_OE_OFF,
        default: '0
    };

    acs_dev_st_t          r;
    acs_dev_st_t          n;
    logic [`ACS_SY_W-1:0] pins;
    logic [`ACS_SY_W-1:0] diff;
    logic [`ACS_SY_W-1:0] upd;
    logic [`ACS_SY_W-1:0] rise_v;
    logic [`ACS_SY_W-1:0] fall_v;
    logic [11:0]          db_f;
    logic                 seq_on;
    logic [1:0]           sel_ch;
    logic [1:0]           last_ch;
    logic                 auto_pd;

    // ****************************************************************
    // Pin filtering and edge detection
    // ****************************************************************
    assign pins = {LINK.db, LINK.word_mode, LINK.mclk, LINK.rd_n,
                   LINK.wr_n, LINK.cs_n, LINK.conversion_start_n_n};
    assign diff   = r.sy2 ^ r.sy3;
    assign upd    = ~diff & (r.sy2 ^ r.filt);
    assign rise_v = upd & ~r.filt;
    assign fall_v = upd & r.filt;
    assign db_f   = r.filt[`ACS_SY_DB_HI:`ACS_SY_DB_LO];

    // ****************************************************************
    // Channel selection
    // ****************************************************************
    assign seq_on  = r.ctrl[`ACS_CR_CHAN_ORDER_BIT1] & r.ctrl[`ACS_CR_CHAN_ORDER_BIT0]; // [RQ20]
    assign last_ch = r.ctrl[`ACS_CR_CHANNEL_INDEX_BIT1:`ACS_CR_CHANNEL_INDEX_BIT0];            // [RQ19]
    assign sel_ch  = seq_on ? r.seq_ch : last_ch;                  // [RQ1]
    assign auto_pd =
        (r.ctrl[`ACS_CR_PM_HI:`ACS_CR_PM_LO] == `ACS_PM_AUTOSHDN) ||
        (r.ctrl[`ACS_CR_PM_HI:`ACS_CR_PM_LO] == `ACS_PM_AUTOSTBY);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        n = r;
        n.sy1 = pins;
        n.sy2 = r.sy1;
        n.sy3 = r.sy2;
        n.filt = (r.sy2 & ~diff) | (r.filt & diff);
        n.mux_ch = sel_ch;

        // Conversion sequencing
        case (r.state)
            D_IDLE: begin
                if (fall_v[`ACS_SY_CONVERSION_START_N]) begin
                    n.state = D_CONV;                 // [RQ7]
                    n.busy = 1'h1;                    // [RQ8]
                    n.hold = 1'h1;                    // [RQ10]
                    n.rise_cnt = 4'h0;
                    n.fall_cnt = 4'h0;
                    n.cur_ch = r.mux_ch;
                    n.sample = SAMPLE_I;
                end else if (rise_v[`ACS_SY_CONVERSION_START_N]) begin
                    n.hold = 1'h0;                    // [RQ11]
                    n.pdown = 1'h0;                   // [RQ13]
                end
            end
            D_CONV: begin
                if (fall_v[`ACS_SY_MCLK] &&
                    r.fall_cnt + 4'h1 == `ACS_DONE_FALL) begin
                    n.state = D_IDLE;
                    n.busy = 1'h0;                    // [RQ8]
                    n.result = r.sample;
                    n.res_ch = r.cur_ch;
                    if (seq_on) begin
                        if (r.cur_ch == last_ch) begin
                            n.seq_ch = 2'h0;          // [RQ4]
                        end else begin
                            n.seq_ch = r.cur_ch + 2'h1; // [RQ3]
                        end
                    end
                    if (auto_pd) begin
                        n.pdown = 1'h1;
                        n.hold = 1'h1;
                    end
                end else if (rise_v[`ACS_SY_CONVERSION_START_N]) begin
                    n.state = D_IDLE;                 // [RQ9]
                    n.busy = 1'h0;
                    n.hold = 1'h0;
                end else if (fall_v[`ACS_SY_MCLK]) begin
                    n.fall_cnt = r.fall_cnt + 4'h1;
                end else if (rise_v[`ACS_SY_MCLK]) begin
                    n.rise_cnt = r.rise_cnt + 4'h1;
                    if (r.rise_cnt + 4'h1 == `ACS_TRACK_RISE) begin
                        n.hold = 1'h0;                // [RQ10]
                    end
                end
            end
            default: begin
                n.state = D_IDLE;
            end
        endcase

        // Control register writes
        if (rise_v[`ACS_SY_WR] && !r.filt[`ACS_SY_CS]) begin  // [RQ17]
            if (r.filt[`ACS_SY_WB]) begin                    // [RQ14]
                n.ctrl = db_f;
                n.seq_ch = 2'h0;                              // [RQ3]
            end else if (db_f[`ACS_HBS_BIT]) begin
                n.ctrl = {db_f[3:0], r.stage};
                n.seq_ch = 2'h0;                              // [RQ3]
            end else begin
                n.stage = db_f[7:0];
            end
        end

        // Result read drive
        n.dout = 12'h000;
        n.oe_n = `ACS_OE_OFF;
        if (!r.filt[`ACS_SY_CS] && !r.filt[`ACS_SY_RD]) begin
            if (r.filt[`ACS_SY_WB]) begin                    // [RQ14]
                n.oe_n = `ACS_OE_ON;
                n.dout = r.result;
            end else if (db_f[`ACS_HBS_BIT]) begin
                n.oe_n = `ACS_OE_BYTE;
                n.dout = {6'h00, r.res_ch, r.result[11:8]};   // [RQ16]
            end else begin
                n.oe_n = `ACS_OE_BYTE;
                n.dout = {4'h0, r.result[7:0]};
            end
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            r <= DEV_RST;                                     // [RQ18]
        end else begin
            r <= n;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign LINK.busy        = r.busy;
    assign LINK.dev_db      = r.dout;
    assign LINK.dev_db_oe_n = r.oe_n;
    assign CHANNEL_O        = r.mux_ch;
    assign HOLD_O           = r.hold;
    assign REF_INTERNAL_O   = r.ctrl[`ACS_CR_REF];               // [RQ6]
    assign INPUT_CONFIG_O   = r.ctrl[`ACS_CR_INPUT_CONFIG_BIT1:`ACS_CR_INPUT_CONFIG_BIT0];
    assign POWER_MODE_O     = r.ctrl[`ACS_CR_PM_HI:`ACS_CR_PM_LO];
    assign POWER_DOWN_O     = r.pdown;
endmodule

// ===== verif/acs_assertions.sv
`timescale 1ns/100ps
module acs_assertions (
    input wire logic        CLK_I,
    input wire logic        RST_N_I,
    input wire logic        conversion_start_n_n,
    input wire logic        cs_n,
    input wire logic        wr_n,
    input wire logic        rd_n,
    input wire logic        word_mode,
    input wire logic        busy,
    input wire logic [11:0] dev_db_oe_n,
    input wire logic [11:0] db
);
    // ****************************************************
    // Cycles spent with start high
    // ****************************************************
    typedef struct packed {logic [4:0] hi;} acs_chk_t;
    acs_chk_t chk_reg;
    acs_chk_t chk_next;
    always_comb begin
        chk_next = chk_reg;
        chk_next.hi = conversion_start_n_n ? chk_reg.hi + 5'(chk_reg.hi != 5'h1F) : 5'h00;
    end
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I)
            chk_reg <= '0;
        else
            chk_reg <= chk_next;
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence s_rd_on; (!cs_n && !rd_n)[*8]; endsequence
    sequence s_rd_off; (cs_n || rd_n)[*8]; endsequence
    busy_start_a: assert property (
        $fell(conversion_start_n_n) && !busy |-> ##[1:8] busy) else $error("no busy");
    busy_cause_a: assert property (
        $rose(busy) |-> !conversion_start_n_n && !$past(conversion_start_n_n, 2))
        else $error("busy without start");
    busy_len_a: assert property (
        $rose(busy) |-> ##[96:120] $fell(busy)) else $error("busy length");
    acq_time_a: assert property (
        $fell(conversion_start_n_n) |-> chk_reg.hi >= 5'h0D) else $error("short track");
    start_rise_a: assert property (
        $rose(conversion_start_n_n) |-> !busy) else $error("early start rise");
    write_idle_a: assert property (
        busy |-> wr_n) else $error("write during conversion");
    write_sel_a: assert property (
        !wr_n |-> !cs_n) else $error("write without select");
    read_drive_a: assert property (
        s_rd_on |-> dev_db_oe_n == (word_mode ? 12'h000 : 12'hF00))
        else $error("read not driven");
    read_release_a: assert property (
        s_rd_off |-> dev_db_oe_n == 12'hFFF) else $error("bus not released");
    high_byte_a: assert property (
        (db[8] && dev_db_oe_n == 12'hF00)[*2] |-> db[7:6] == 2'h0)
        else $error("high byte top bits");
endmodule

// ===== verif/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic        clk;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hrdy;
    logic [31:0] hrdata;
    logic        hresp;
    logic [11:0] sample;
    logic [11:0] smp [4];
    logic [1:0]  chan;
    logic        hold;
    logic        ref_int;
    logic [1:0]  cfg;
    logic [1:0]  pwr;
    logic        pdn;
    int          pd_cyc;
    int          pd_base;
    logic [31:0] r;
    logic [11:0] d;
    int          compares;
    int          miscompares;
    int          cyc;

    acs_if u_acs_if ();
    acs_dev u_acs_dev (.CLK_I(clk), .RST_N_I(rst_n), .LINK(u_acs_if),
        .SAMPLE_I(sample), .CHANNEL_O(chan), .HOLD_O(hold),
        .REF_INTERNAL_O(ref_int), .INPUT_CONFIG_O(cfg),
        .POWER_MODE_O(pwr), .POWER_DOWN_O(pdn));
    acs_host u_acs_host (.CLK_I(clk), .RST_N_I(rst_n), .LINK(u_acs_if),
        .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hrdy), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
        .HRDATA_O(hrdata));
    acs_assertions u_acs_assertions (.CLK_I(clk), .RST_N_I(rst_n),
        .conversion_start_n_n(u_acs_if.conversion_start_n_n), .cs_n(u_acs_if.cs_n),
        .wr_n(u_acs_if.wr_n), .rd_n(u_acs_if.rd_n),
        .word_mode(u_acs_if.word_mode), .busy(u_acs_if.busy),
        .dev_db_oe_n(u_acs_if.dev_db_oe_n), .db(u_acs_if.db));

    always #5 clk = ~clk;
    always @(posedge clk) begin
        sample <= smp[chan];
        pd_cyc <= pd_cyc + int'(pdn === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            print_verdict();
        end
    end

    // ****************************************************
    // Bus and check tasks
    // ****************************************************
    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] v);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= v;
        do @(posedge clk); while (hrdy !== 1'b1);
        r = hrdata;
    endtask
    task automatic idle();
        r = 32'h1;
        while (r[0] !== 1'b0)
            ahb(1'b0, 8'h04, 32'h0);
    endtask
    task automatic ctl(input logic [11:0] v);
        ahb(1'b1, 8'h00, {20'h0, v});
        ahb(1'b1, 8'h04, 32'h1);
        idle();
    endtask
    task automatic conv();
        foreach (smp[k]) smp[k] = 12'($urandom);
        ahb(1'b1, 8'h04, 32'h2);
        idle();
        ahb(1'b0, 8'h0C, 32'h0);
    endtask
    function automatic logic [31:0] res_exp(input int ch, input logic bm);
        return {1'b1, 17'h0, bm ? 2'(ch) : 2'h0, smp[ch]};
    endfunction

    initial begin
        {clk, rst_n, hsel, hwrite} = 4'h0;
        {haddr, hwdata, htrans} = '0;
        foreach (smp[k]) smp[k] = 12'h000;
        {compares, miscompares} = '0;
        void'($urandom(2));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        chk({30'h0, pwr}, 32'h0);
        chk({31'h0, hold}, 32'h1);
        idle();
        for (int i = 0; i < 8; i++) begin
            d = {2'h0, 2'(i % 3), 2'(i % 4), 2'($urandom), 1'($urandom), 3'h0};
            ctl(d);
            chk({31'h0, ref_int}, {31'h0, d[3]});
            chk({30'h0, cfg}, {30'h0, d[5:4]});
            conv();
            chk(r, res_exp(i % 4, 1'b0));
            chk({31'h0, hold}, 32'h0);
        end
        ctl(12'h380);
        for (int i = 0; i < 5; i++) begin
            conv();
            chk(r, res_exp(i % 3, 1'b0));
        end
        ctl(12'h3C8);
        conv();
        chk(r, res_exp(0, 1'b0));
        ahb(1'b0, 8'h0C, 32'h0);
        chk(r & 32'h80000000, 32'h0);
        ahb(1'b1, 8'h08, 32'h0);
        ctl(12'h0C0);
        conv();
        chk(r, res_exp(3, 1'b1));
        ahb(1'b1, 8'h08, 32'h1);
        for (int m = 1; m < 3; m++) begin
            ctl({2'(m), 10'h040});
            pd_base = pd_cyc;
            conv();
            chk(r, res_exp(1, 1'b0));
            chk({30'h0, pd_cyc > pd_base, pdn}, 32'h2);
        end
        ahb(1'b0, 8'h40, 32'h0);
        chk(r, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        print_verdict();
    end
endmodule
